// file: design/pmusm_pkg.sv
// shared constants and types for the pmu state and mode controller
package pmusm_pkg;
  // clock rate and derived cycle counts
  localparam int CLK_KHZ = 40000;
  localparam int PWM_FREQ_KHZ = 1000;
  localparam int PWM_PERIOD_CYC = CLK_KHZ / PWM_FREQ_KHZ;
  localparam int PWRUP_STEP_NS = 1000;
  localparam int PWRUP_STEP_CYC = (PWRUP_STEP_NS * CLK_KHZ + 999999) / 1000000;
  localparam int LINK_IDLE_NS = 2000;
  localparam int LINK_IDLE_CYC = (LINK_IDLE_NS * CLK_KHZ) / 1000000;
  localparam int LIGHT_LOAD_CYC = 64;
  // core target: 128 linear steps between 0.6 V and 1.2 V
  localparam int CORE_STEPS = 128;
  localparam int CORE_MV_MIN = 600;
  localparam int CORE_MV_MAX = 1200;
  // serial frame layout: command, address, data
  localparam int FRAME_BITS = 16;
  localparam int TX_BITS = 8;
  localparam int FRM_CMD_LSB = 12;
  localparam int FRM_ADR_LSB = 8;
  // register addresses, fields and reset values
  localparam logic [3:0] ADR_CORE = 4'h4;
  localparam logic [3:0] ADR_RET = 4'h5;
  localparam logic [3:0] ADR_FORCE = 4'h9;
  localparam logic [3:0] ADR_MFR = 4'hF;
  localparam int FORCE_PFM_BIT = 7;
  localparam int FORCE_PWM_BIT = 6;
  localparam logic [6:0] CORE_RST = 7'h40;
  localparam logic [3:0] RET_RST = 4'h3;
  localparam logic [1:0] FORCE_RST = 2'h0;
  localparam logic [7:0] MFR_RST = 8'h5A; // arbitrary value
  typedef enum logic [3:0] {
    CMD_CORE_ADJ = 4'h1, CMD_RESET = 4'h2, CMD_SLEEP = 4'h3, CMD_SHUTDOWN = 4'h4,
    CMD_WAKEUP = 4'h5, CMD_REG_READ = 4'h6, CMD_REG_WRITE = 4'h7, CMD_AUTH = 4'h8,
    CMD_SYNC = 4'h9
  } pmusm_cmd_t;
  typedef enum logic [4:0] {
    ST_STARTUP = 5'h01, ST_POWERUP = 5'h02, ST_ACTIVE = 5'h04, ST_SLEEP = 5'h08,
    ST_SHUTDOWN = 5'h10
  } pmusm_state_t;
  typedef enum logic [3:0] {
    PS_IDLE = 4'h1, PS_HS = 4'h2, PS_LS_RETRY = 4'h4, PS_LS_END = 4'h8
  } pmusm_skip_t;
endpackage

// file: design/pmusm_link.sv
// serial link front end: samples link clock and data, frames commands, shifts replies
`timescale 1ns/1ps
module pmusm_link
  import pmusm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_link_en,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_tx_load,
  input wire logic [7:0] i_tx_data,
  output logic o_frame_valid,
  output logic [FRAME_BITS-1:0] o_frame,
  output logic o_sdata,
  output logic o_sdata_oe
);
  if (LINK_IDLE_CYC > 255 || LINK_IDLE_CYC < 1) begin : g_bad_idle
    $error("link idle count does not fit its counter");
  end
  logic [1:0] clk_sync;
  logic [1:0] dat_sync;
  logic clk_d, rise, fall, next_valid, next_sdata, next_oe;
  logic [FRAME_BITS-1:0] shreg, next_shreg, next_frame;
  logic [4:0] bitcnt, next_bitcnt;
  logic [7:0] idle, next_idle;
  logic [TX_BITS-1:0] txsh, next_txsh;
  logic [3:0] txcnt, next_txcnt;

  // edges are found on the second synchroniser stage only
  assign rise = clk_sync[1] & ~clk_d;
  assign fall = ~clk_sync[1] & clk_d;

  // framing and reply shifting; rising edges are ignored while a reply owns the line
  always_comb begin
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_idle = idle;
    next_txsh = txsh;
    next_txcnt = txcnt;
    next_valid = 1'b0;
    next_frame = o_frame;
    next_sdata = o_sdata;
    next_oe = o_sdata_oe;
    if (!i_link_en) begin
      next_bitcnt = '0;
      next_idle = '0;
      next_txcnt = '0;
      next_sdata = 1'b0;
      next_oe = 1'b0;
    end else begin
      if (rise || fall) begin
        next_idle = '0;
      end else if (idle != 8'(LINK_IDLE_CYC)) begin
        next_idle = idle + 8'h01;
      end
      if (idle == 8'(LINK_IDLE_CYC)) begin // a stalled host realigns framing
        next_bitcnt = '0;
        next_txcnt = '0;
        next_oe = 1'b0;
        next_sdata = 1'b0;
      end
      if (fall && (txcnt != 4'h0 || o_sdata_oe)) begin
        next_oe = (txcnt != 4'h0);
        next_sdata = txsh[TX_BITS-1] & (txcnt != 4'h0);
        next_txsh = {txsh[TX_BITS-2:0], 1'b0};
        if (txcnt != 4'h0) begin
          next_txcnt = txcnt - 4'h1;
        end
      end else if (rise && txcnt == 4'h0 && !o_sdata_oe) begin
        next_shreg = {shreg[FRAME_BITS-2:0], dat_sync[1]};
        if (bitcnt == 5'(FRAME_BITS-1)) begin
          next_valid = 1'b1;
          next_frame = next_shreg;
          next_bitcnt = '0;
        end else begin
          next_bitcnt = bitcnt + 5'h01;
        end
      end
      if (i_tx_load) begin
        next_txsh = i_tx_data;
        next_txcnt = 4'(TX_BITS);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_sync <= 2'h0;
      dat_sync <= 2'h0;
      clk_d <= 1'b0;
      shreg <= '0;
      bitcnt <= '0;
      idle <= '0;
      txsh <= '0;
      txcnt <= '0;
      o_frame_valid <= 1'b0;
      o_frame <= '0;
      o_sdata <= 1'b0;
      o_sdata_oe <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], i_sclk};
      dat_sync <= {dat_sync[0], i_sdata};
      clk_d <= clk_sync[1];
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      idle <= next_idle;
      txsh <= next_txsh;
      txcnt <= next_txcnt;
      o_frame_valid <= next_valid;
      o_frame <= next_frame;
      o_sdata <= next_sdata;
      o_sdata_oe <= next_oe;
    end
  end
endmodule

// file: design/pmusm_conv.sv
// converter switch control: fixed-frequency and pulse-skipping modes
`timescale 1ns/1ps
module pmusm_conv
  import pmusm_pkg::*;
#(
  parameter int PERIOD_CYC = PWM_PERIOD_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_run,
  input wire logic [1:0] i_force,
  input wire logic [5:0] i_on_time,
  input wire logic i_valley_neg,
  input wire logic i_peak_low,
  input wire logic i_below_low,
  input wire logic i_above_high,
  input wire logic i_skip_peak_current_limit,
  input wire logic i_il_zero,
  output logic o_hs_on,
  output logic o_ls_on,
  output logic o_pfm
);
  if (PERIOD_CYC < 2 || PERIOD_CYC > 64) begin : g_bad_period
    $error("pwm period does not fit the period counter");
  end
  logic [5:0] cmp_s1, cmp_s2, pcnt, next_pcnt, on_lim;
  logic [6:0] lcnt, next_lcnt;
  logic valley, peak_low, below, above, limit, zero, light, auto_mode;
  logic next_hs, next_ls, next_pfm;
  pmusm_skip_t ps, next_ps;

  assign {valley, peak_low, below, above, limit, zero} = cmp_s2;
  assign light = valley | peak_low;
  assign auto_mode = (i_force[1] == i_force[0]);
  // an on-time of a full period would leave no low-side half
  assign on_lim = (i_on_time > 6'(PERIOD_CYC-1)) ? 6'(PERIOD_CYC-1) : i_on_time;

  // mode choice and switch sequencing
  always_comb begin
    next_pcnt = pcnt;
    next_lcnt = '0;
    next_ps = ps;
    next_pfm = o_pfm;
    next_hs = 1'b0;
    next_ls = 1'b0;
    if (!i_run) begin
      next_pfm = 1'b0;
      next_pcnt = '0;
      next_ps = PS_IDLE;
    end else begin
      if (!auto_mode) begin
        next_pfm = i_force[1];
      end else if (light != o_pfm) begin
        next_lcnt = lcnt + 7'h01;
        if (lcnt == 7'(LIGHT_LOAD_CYC-1)) begin
          next_pfm = ~o_pfm;
          next_lcnt = '0;
        end
      end
      if (!o_pfm) begin
        next_ps = PS_IDLE;
        next_pcnt = (pcnt == 6'(PERIOD_CYC-1)) ? 6'h00 : pcnt + 6'h01;
        next_hs = (pcnt < on_lim);
        next_ls = !next_hs;
      end else begin
        next_pcnt = '0;
        case (ps)
          PS_IDLE: if (below) next_ps = PS_HS;
          PS_HS: begin
            if (above) begin
              next_ps = PS_LS_END;
            end else if (limit) begin
              next_ps = PS_LS_RETRY;
            end
          end
          PS_LS_RETRY: if (zero) next_ps = PS_HS;
          PS_LS_END: if (zero) next_ps = PS_IDLE;
          default: next_ps = PS_IDLE;
        endcase
        next_hs = (next_ps == PS_HS);
        next_ls = (next_ps == PS_LS_RETRY) || (next_ps == PS_LS_END);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_s1 <= '0;
      cmp_s2 <= '0;
      pcnt <= '0;
      lcnt <= '0;
      ps <= PS_IDLE;
      o_pfm <= 1'b0;
      o_hs_on <= 1'b0;
      o_ls_on <= 1'b0;
    end else begin
      cmp_s1 <= {i_valley_neg, i_peak_low, i_below_low, i_above_high,
                 i_skip_peak_current_limit, i_il_zero};
      cmp_s2 <= cmp_s1;
      pcnt <= next_pcnt;
      lcnt <= next_lcnt;
      ps <= next_ps;
      o_pfm <= next_pfm;
      o_hs_on <= next_hs;
      o_ls_on <= next_ls;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_auto_entry_delay: assert property ($rose(o_pfm) && $past(auto_mode) |->
    $past(lcnt) == 7'(LIGHT_LOAD_CYC-1) && $past(light))
    else $error("pulse-skip entered before the light-load time");
  chk_pwm_period_wrap: assert property (i_run && !o_pfm && pcnt == 6'h00 && $past(pcnt) != 6'h00
    |-> $past(pcnt) == 6'(PERIOD_CYC-1) && !o_hs_on && o_ls_on)
    else $error("fixed-frequency period has the wrong length");
  chk_skip_high_hold: assert property (o_pfm && i_run && ps == PS_LS_END && !zero
    |=> !o_hs_on && o_ls_on)
    else $error("high side turned on before the low threshold");
  chk_skip_low_start: assert property (o_pfm && i_run && ps == PS_IDLE && below && $past(o_pfm)
    |=> o_hs_on && !o_ls_on)
    else $error("high side did not start below the low threshold");
  cov_enter_skip: cover property ($rose(o_pfm) && auto_mode);
  cov_limit_retry: cover property (ps == PS_LS_RETRY ##1 ps == PS_HS);
endmodule

// file: design/pmusm_top.sv
// power state sequencer, register file and converter mode control
`timescale 1ns/1ps
// How it works
// - five power states steer regulators and power-good
// - after reset: start-up, regulators off, power-good low
// - enable and reset pins high: run power-up sequence, then active
// - active: all regulators on, power-good high
// - active from start-up uses default voltage settings
// - active: shutdown command or pin low ends
// - active: sleep command enters sleep
// - sleep: core off, power-good stays high
// - sleep: retention voltage, pll and io on
// - wake-up returns active with programmed settings
// - sleep: shutdown command or pin low ends
// - shutdown: outputs zero, power-good low
// - shutdown left for start-up when pin low
// - core target seven bits, 128 linear steps
// - serial link takes the nine command kinds
// - fixed mode: 1 MHz, high then low side
// - auto pulse-skip after 64 light-load cycles
// - below low threshold: high side until limit
// - limit trip: low side, retry at zero current
// - high threshold trip: wait for low threshold
// - low side off at zero inductor current
// - two force bits pick auto, skip or fixed
module pmusm_top
  import pmusm_pkg::*;
#(
  parameter int STEP_CYC = PWRUP_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_hw_rst_low,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_valley_neg,
  input wire logic i_peak_low,
  input wire logic i_below_low,
  input wire logic i_above_high,
  input wire logic i_skip_peak_current_limit,
  input wire logic i_il_zero,
  input wire logic [5:0] i_pwm_on_time,
  output logic o_sdata,
  output logic o_sdata_oe,
  output logic o_power_good_output,
  output logic o_core_en,
  output logic [6:0] o_core_code,
  output logic o_pll_supply_regulator_en,
  output logic o_io_supply_regulator_en,
  output logic o_retention_supply_output_en,
  output logic o_retention_hold,
  output logic [3:0] o_retention_code,
  output logic o_hs_on,
  output logic o_ls_on,
  output logic o_pfm_active,
  output logic [4:0] o_power_state
);
  if (STEP_CYC < 1 || STEP_CYC > 65535) begin : g_bad_step
    $error("power-up step count does not fit its counter");
  end
  pmusm_state_t state, next_state;
  logic [1:0] en_sync;
  logic [1:0] rn_sync;
  logic [1:0] seq, next_seq;
  logic [15:0] step, next_step;
  logic pins_ok, ctl_ok, frame_valid, tx_load;
  logic [FRAME_BITS-1:0] frame;
  pmusm_cmd_t cmd;
  logic [3:0] adr;
  logic [7:0] data, tx_data, mfr, next_mfr;
  logic [6:0] core, next_core;
  logic [3:0] ret, next_ret;
  logic [1:0] force_sel, next_force;
  logic next_pg, next_core_en, next_pll_en, next_io_en, next_ret_en, next_hold;

  // both pins must be high before the device may leave start-up
  assign pins_ok = en_sync[1] & rn_sync[1];
  // register and state commands count only once the rails are up
  assign ctl_ok = (state == ST_ACTIVE) || (state == ST_SLEEP);
  assign cmd = pmusm_cmd_t'(frame[FRAME_BITS-1:FRM_CMD_LSB]);
  assign adr = frame[FRM_CMD_LSB-1:FRM_ADR_LSB];
  assign data = frame[FRM_ADR_LSB-1:0];

  // a frame carrying command c has arrived while commands are served
  function automatic logic got(input pmusm_cmd_t c);
    return frame_valid && ctl_ok && (cmd == c);
  endfunction

  // read-back view; unmapped addresses answer an all-zero byte
  function automatic logic [7:0] reg_rd(input logic [3:0] a);
    case (a)
      ADR_CORE: reg_rd = {1'b0, core};
      ADR_RET: reg_rd = {4'h0, ret};
      ADR_FORCE: reg_rd = {force_sel, 6'h00};
      ADR_MFR: reg_rd = mfr;
      default: reg_rd = 8'h00;
    endcase
  endfunction

  // the link is cut off in shutdown; only the pins can wake the device
  pmusm_link u_link (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_link_en(state != ST_SHUTDOWN),
    .i_sclk(i_sclk),
    .i_sdata(i_sdata),
    .i_tx_load(tx_load),
    .i_tx_data(tx_data),
    .o_frame_valid(frame_valid),
    .o_frame(frame),
    .o_sdata(o_sdata),
    .o_sdata_oe(o_sdata_oe)
  );

  pmusm_conv u_conv (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_run(o_core_en),
    .i_force(force_sel),
    .i_on_time(i_pwm_on_time),
    .i_valley_neg(i_valley_neg),
    .i_peak_low(i_peak_low),
    .i_below_low(i_below_low),
    .i_above_high(i_above_high),
    .i_skip_peak_current_limit(i_skip_peak_current_limit),
    .i_il_zero(i_il_zero),
    .o_hs_on(o_hs_on),
    .o_ls_on(o_ls_on),
    .o_pfm(o_pfm_active)
  );

  // power state machine with a four-step power-up ramp
  always_comb begin
    next_state = state;
    next_seq = seq;
    next_step = step;
    case (state)
      ST_STARTUP: begin
        if (pins_ok) begin
          next_state = ST_POWERUP;
          next_seq = 2'h0;
          next_step = 16'h0000;
        end
      end
      ST_POWERUP: begin
        if (!pins_ok) begin
          next_state = ST_STARTUP;
        end else if (step != 16'(STEP_CYC-1)) begin
          next_step = step + 16'h0001;
        end else begin
          next_step = 16'h0000;
          if (seq == 2'h3) begin
            next_state = ST_ACTIVE;
          end else begin
            next_seq = seq + 2'h1;
          end
        end
      end
      ST_ACTIVE: begin
        if (!pins_ok || got(CMD_SHUTDOWN)) begin
          next_state = ST_SHUTDOWN;
        end else if (got(CMD_SLEEP)) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!pins_ok || got(CMD_SHUTDOWN)) begin
          next_state = ST_SHUTDOWN;
        end else if (got(CMD_WAKEUP)) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_SHUTDOWN: if (!pins_ok) next_state = ST_STARTUP;
      default: next_state = ST_STARTUP;
    endcase
  end

  // register file; defaults reload on every power-up from start-up
  always_comb begin
    next_core = core;
    next_ret = ret;
    next_force = force_sel;
    next_mfr = mfr;
    tx_load = 1'b0;
    tx_data = 8'h00;
    if (state == ST_STARTUP && pins_ok) begin
      next_core = CORE_RST;
      next_ret = RET_RST;
      next_force = FORCE_RST;
    end else if (frame_valid && ctl_ok) begin
      case (cmd)
        CMD_CORE_ADJ: next_core = data[6:0];
        CMD_RESET: begin
          next_core = CORE_RST;
          next_ret = RET_RST;
          next_force = FORCE_RST;
        end
        CMD_REG_WRITE: begin
          case (adr)
            ADR_CORE: next_core = data[6:0];
            ADR_RET: next_ret = data[3:0];
            ADR_FORCE: next_force = data[FORCE_PFM_BIT:FORCE_PWM_BIT];
            ADR_MFR: next_mfr = data;
            default: next_mfr = mfr;
          endcase
        end
        CMD_REG_READ: begin
          tx_load = 1'b1;
          tx_data = reg_rd(adr);
        end
        CMD_AUTH: begin
          tx_load = 1'b1;
          tx_data = mfr;
        end
        default: tx_load = 1'b0; // sleep, wake-up, sync: no register effect
      endcase
    end
  end

  // outputs follow the next state so they line up with the state register
  always_comb begin
    next_pg = (next_state == ST_ACTIVE) || (next_state == ST_SLEEP);
    next_pll_en = next_pg || (next_state == ST_POWERUP);
    next_io_en = next_pg || (next_state == ST_POWERUP && next_seq >= 2'h1);
    next_core_en = (next_state == ST_ACTIVE) || (next_state == ST_POWERUP && next_seq >= 2'h2);
    next_ret_en = next_pg || (next_state == ST_POWERUP && next_seq == 2'h3);
    next_hold = (next_state == ST_SLEEP);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_sync <= 2'h0;
      rn_sync <= 2'h0;
      state <= ST_STARTUP;
      seq <= 2'h0;
      step <= 16'h0000;
      core <= CORE_RST;
      ret <= RET_RST;
      force_sel <= FORCE_RST;
      mfr <= MFR_RST;
      o_power_good_output <= 1'b0;
      o_core_en <= 1'b0;
      o_pll_supply_regulator_en <= 1'b0;
      o_io_supply_regulator_en <= 1'b0;
      o_retention_supply_output_en <= 1'b0;
      o_retention_hold <= 1'b0;
      o_core_code <= 7'h00;
      o_retention_code <= 4'h0;
      o_power_state <= ST_STARTUP;
    end else begin
      en_sync <= {en_sync[0], i_enable};
      rn_sync <= {rn_sync[0], i_hw_rst_low};
      state <= next_state;
      seq <= next_seq;
      step <= next_step;
      core <= next_core;
      ret <= next_ret;
      force_sel <= next_force;
      mfr <= next_mfr;
      o_power_good_output <= next_pg;
      o_core_en <= next_core_en;
      o_pll_supply_regulator_en <= next_pll_en;
      o_io_supply_regulator_en <= next_io_en;
      o_retention_supply_output_en <= next_ret_en;
      o_retention_hold <= next_hold;
      // codes read zero whenever the rail they set is off
      o_core_code <= next_core_en ? next_core : 7'h00;
      o_retention_code <= next_ret_en ? next_ret : 4'h0;
      o_power_state <= next_state;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_state_onehot: assert property ($onehot(state) && o_power_state == state)
    else $error("power state not one-hot or not shown");
  chk_startup_off: assert property (state == ST_STARTUP |->
    !o_power_good_output && !o_core_en && !o_pll_supply_regulator_en &&
    !o_io_supply_regulator_en && !o_retention_supply_output_en)
    else $error("start-up with a regulator or power-good on");
  chk_powerup_start: assert property (state == ST_STARTUP && pins_ok |=>
    state == ST_POWERUP && o_pll_supply_regulator_en && !o_core_en)
    else $error("enable did not start the power-up ramp");
  chk_active_rails: assert property (state == ST_ACTIVE |-> o_power_good_output &&
    o_core_en && o_pll_supply_regulator_en && o_io_supply_regulator_en &&
    o_retention_supply_output_en && !o_retention_hold)
    else $error("active state with a rail off");
  chk_active_defaults: assert property ($past(state) == ST_POWERUP && state == ST_ACTIVE
    |-> core == CORE_RST && ret == RET_RST && force_sel == FORCE_RST && o_core_code == CORE_RST)
    else $error("first active entry not at default settings");
  chk_active_exit: assert property (state == ST_ACTIVE && (!pins_ok || got(CMD_SHUTDOWN))
    |=> state == ST_SHUTDOWN ##1 !o_sdata_oe)
    else $error("active did not shut down");
  chk_sleep_entry: assert property (state == ST_ACTIVE && pins_ok && got(CMD_SLEEP)
    |=> state == ST_SLEEP && !o_core_en)
    else $error("sleep command not obeyed");
  chk_sleep_rails: assert property (state == ST_SLEEP |-> o_power_good_output &&
    !o_core_en && o_retention_hold && o_retention_code == ret &&
    o_pll_supply_regulator_en && o_io_supply_regulator_en)
    else $error("sleep rails wrong");
  chk_wake_keeps: assert property (state == ST_SLEEP && pins_ok && got(CMD_WAKEUP)
    |=> state == ST_ACTIVE && $stable(core) && o_core_code == core)
    else $error("wake-up lost the programmed settings");
  chk_sleep_exit: assert property (state == ST_SLEEP && (!pins_ok || got(CMD_SHUTDOWN))
    |=> state == ST_SHUTDOWN)
    else $error("sleep did not shut down");
  chk_shutdown_zero: assert property (state == ST_SHUTDOWN |-> !o_power_good_output &&
    !o_core_en && !o_pll_supply_regulator_en && !o_io_supply_regulator_en &&
    !o_retention_supply_output_en && o_core_code == 7'h00 && o_retention_code == 4'h0)
    else $error("shutdown with an output alive");
  chk_shutdown_leave: assert property (state == ST_SHUTDOWN && !pins_ok |=>
    state == ST_STARTUP ##1 (state == ST_STARTUP || state == ST_POWERUP))
    else $error("shutdown not left for start-up");
  chk_stray_wake: assert property (state == ST_ACTIVE && pins_ok && got(CMD_WAKEUP)
    |=> state == ST_ACTIVE && $stable(core) && $stable(ret) && $stable(force_sel))
    else $error("misplaced wake-up changed the device");
  cov_full_cycle: cover property (state == ST_POWERUP ##1 state == ST_ACTIVE);
  cov_sleep_wake: cover property (state == ST_SLEEP ##1 state == ST_ACTIVE);
  cov_cmd_shutdown: cover property (state == ST_ACTIVE && got(CMD_SHUTDOWN));
endmodule

// file: test/pmusm_host.sv
// host side model: serial link master of the power controller
`timescale 1ns/1ps
module pmusm_host (
  input wire logic i_clk,
  input wire logic i_sdata,
  output logic o_sclk,
  output logic o_sdata
);
  // link clock stands low between frames
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
  end
  task automatic half(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // frame msb first, data set while clock low; never aimed at the maker register
  task automatic send(input logic [15:0] f);
    for (int b = 15; b >= 0; b--) begin
      o_sdata <= f[b];
      half(4);
      o_sclk <= 1'b1;
      half(4);
      o_sclk <= 1'b0;
    end
    o_sdata <= ~f[0]; // released line shows no stale bit
    half(12);
  endtask
  // the frame's own last falling edge put bit 7 out; eight more periods collect
  // the rest, and their last falling edge releases the line before a new frame
  task automatic fetch(output logic [7:0] d);
    for (int b = 7; b >= 0; b--) begin
      d[b] = i_sdata;
      o_sclk <= 1'b1;
      half(4);
      o_sclk <= 1'b0;
      half(6);
    end
  endtask
endmodule

// file: test/test_pmusm_top.sv
// self-checking bench for the pmu state and mode controller
`timescale 1ns/1ps
module test_pmusm_top;
  import pmusm_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_enable = 1'b0, i_hw_rst_low = 1'b0;
  logic i_valley_neg = 1'b0, i_peak_low = 1'b0, i_below_low = 1'b0, i_above_high = 1'b0;
  logic i_skip_peak_current_limit = 1'b0, i_il_zero = 1'b0, i_sclk, i_sdata, hdata;
  logic [5:0] i_pwm_on_time = 6'h0A;
  logic o_sdata, o_sdata_oe, o_power_good_output, o_core_en, o_pll_supply_regulator_en;
  logic o_io_supply_regulator_en, o_retention_supply_output_en, o_retention_hold;
  logic o_hs_on, o_ls_on, o_pfm_active;
  logic [6:0] o_core_code;
  logic [3:0] o_retention_code;
  logic [4:0] o_power_state;
  logic [7:0] rd;
  int fail_count = 0;
  int checks = 0;
  always #12.5 i_clk = ~i_clk;
  // wire level of the two-way data pin
  assign i_sdata = o_sdata_oe ? o_sdata : hdata;
  pmusm_top #(.STEP_CYC(2)) pmusm_top_inst (.*);
  pmusm_host pmusm_host_inst (.i_clk(i_clk), .i_sdata(i_sdata), .o_sclk(i_sclk), .o_sdata(hdata));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for a state; running out ends the run
  task automatic wait_st(input logic [4:0] e);
    int n;
    n = 0;
    while (o_power_state !== e && n < 600) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("state", {3'h0, o_power_state}, {3'h0, e});
    if (o_power_state !== e)
      complete_run();
  endtask
  // drive the six converter comparators at an edge and let them pass the synchroniser
  task automatic cmp_set(input logic [5:0] v);
    @(posedge i_clk);
    {i_valley_neg, i_peak_low, i_below_low, i_above_high,
     i_skip_peak_current_limit, i_il_zero} <= v;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic t_up();
    @(posedge i_clk);
    i_enable <= 1'b1;
    i_hw_rst_low <= 1'b1;
    wait_st(ST_ACTIVE);
    chk("pg", o_power_good_output, 8'h01);
    chk("io", o_io_supply_regulator_en, 8'h01);
    chk("core", o_core_code, CORE_RST);
  endtask
  task automatic t_sleep();
    pmusm_host_inst.send({CMD_REG_WRITE, ADR_CORE, 8'h15});
    chk("core wr", o_core_code, 8'h15);
    pmusm_host_inst.send({CMD_WAKEUP, 12'h000});
    chk("wake act", o_power_state, ST_ACTIVE);
    pmusm_host_inst.send({CMD_SLEEP, 12'h000});
    wait_st(ST_SLEEP);
    chk("pg", o_power_good_output, 8'h01);
    chk("core en", o_core_en, 8'h00);
    chk("hold", o_retention_hold, 8'h01);
    chk("pll", o_pll_supply_regulator_en, 8'h01);
    chk("ret en", o_retention_supply_output_en, 8'h01);
    chk("ret code", o_retention_code, RET_RST);
    pmusm_host_inst.send({CMD_WAKEUP, 12'h000});
    wait_st(ST_ACTIVE);
    chk("core kept", o_core_code, 8'h15);
  endtask
  task automatic t_read();
    pmusm_host_inst.send({CMD_AUTH, 12'h000});
    pmusm_host_inst.fetch(rd);
    chk("auth", rd, MFR_RST);
    pmusm_host_inst.send({CMD_REG_READ, 4'hA, 8'h00});
    pmusm_host_inst.fetch(rd);
    chk("unmapped", rd, 8'h00);
    chk("oe off", o_sdata_oe, 8'h00);
  endtask
  task automatic t_conv();
    int h = 0;
    int l = 0;
    // two whole periods hold exactly two on-times whatever the start phase
    repeat (2 * PWM_PERIOD_CYC) begin
      @(posedge i_clk);
      #1;
      h += o_hs_on;
      l += o_ls_on;
    end
    chk("hs cyc", 8'(h), 8'(2 * i_pwm_on_time));
    chk("ls cyc", 8'(l), 8'(2 * (PWM_PERIOD_CYC - i_pwm_on_time)));
    cmp_set(6'h20);
    repeat (LIGHT_LOAD_CYC - 4) @(posedge i_clk);
    chk("skip early", o_pfm_active, 8'h00);
    repeat (3) @(posedge i_clk);
    chk("skip on", o_pfm_active, 8'h01);
    // light load stays on so auto mode keeps pulse-skipping
    cmp_set(6'h28);
    chk("hs below", {o_hs_on, o_ls_on}, 8'h02);
    cmp_set(6'h22);
    chk("ls limit", {o_hs_on, o_ls_on}, 8'h01);
    cmp_set(6'h21);
    chk("hs retry", {o_hs_on, o_ls_on}, 8'h02);
    cmp_set(6'h24);
    chk("ls high", {o_hs_on, o_ls_on}, 8'h01);
    cmp_set(6'h21);
    chk("ls zero", {o_hs_on, o_ls_on}, 8'h00);
    pmusm_host_inst.send({CMD_REG_WRITE, ADR_FORCE, 8'h40});
    chk("force pwm", o_pfm_active, 8'h00);
    pmusm_host_inst.send({CMD_REG_WRITE, ADR_FORCE, 8'h80});
    chk("force skip", o_pfm_active, 8'h01);
    pmusm_host_inst.send({CMD_REG_READ, ADR_FORCE, 8'h00});
    pmusm_host_inst.fetch(rd);
    chk("force rd", rd, 8'h80);
    pmusm_host_inst.send({CMD_CORE_ADJ, 4'h0, 8'h22});
    chk("core adj", o_core_code, 8'h22);
    pmusm_host_inst.send({CMD_RESET, 12'h000});
    chk("core rst", o_core_code, CORE_RST);
    cmp_set(6'h00);
  endtask
  task automatic t_down();
    pmusm_host_inst.send({CMD_SHUTDOWN, 12'h000});
    wait_st(ST_SHUTDOWN);
    chk("pg", o_power_good_output, 8'h00);
    chk("core", o_core_code, 8'h00);
    @(posedge i_clk);
    i_enable <= 1'b0;
    wait_st(ST_STARTUP);
    @(posedge i_clk);
    i_enable <= 1'b1;
    wait_st(ST_ACTIVE);
    chk("core dflt", o_core_code, CORE_RST);
    // a pin dropped in sleep shuts down, then falls back to start-up
    pmusm_host_inst.send({CMD_SLEEP, 12'h000});
    wait_st(ST_SLEEP);
    @(posedge i_clk);
    i_hw_rst_low <= 1'b0;
    wait_st(ST_SHUTDOWN);
    wait_st(ST_STARTUP);
  endtask
  // reset for twelve cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("rst st", o_power_state, ST_STARTUP);
    chk("rst pg", o_power_good_output, 8'h00);
    t_up();
    t_sleep();
    t_read();
    t_conv();
    t_down();
    complete_run();
  end
endmodule
